// ---- shared/tpo_defs.vh ----
// register indices, field layouts, reset values and bus constants of the timing pattern output block
`ifndef TPO_DEFS_VH
`define TPO_DEFS_VH

// ==========================================================================
// register indices (byte address on the bus is four times the index)
// ==========================================================================
`define TPO_IDX_LO_DIR      20'hee009
`define TPO_IDX_HI_DIR      20'hee00a
`define TPO_IDX_NOV_MODE    20'hfffa0
`define TPO_IDX_TRIG_SEL    20'hfffa1
`define TPO_IDX_HI_OE       20'hfffa2
`define TPO_IDX_LO_OE       20'hfffa3
`define TPO_IDX_HI_STG      20'hfffa4
`define TPO_IDX_LO_STG      20'hfffa5
`define TPO_IDX_HI_STG_ALT  20'hfffa6
`define TPO_IDX_LO_STG_ALT  20'hfffa7
`define TPO_IDX_LO_VAL      20'hfffd9
`define TPO_IDX_HI_VAL      20'hfffda

// ==========================================================================
// reset values
// ==========================================================================
`define TPO_RST_DIR         8'h00
`define TPO_RST_NOV         4'h0
`define TPO_RST_TRIG        8'hff
`define TPO_RST_OE          8'h00
`define TPO_RST_STG         8'h00
`define TPO_RST_VAL         4'h0

// ==========================================================================
// field layouts and fixed read values
// ==========================================================================
`define TPO_NOV_RSVD        4'hf
`define TPO_NIB_ONES        4'hf
`define TPO_BYTE_ONES       8'hff
`define TPO_WO_READ         8'h00
`define TPO_TRIG_CH0        2'h0
`define TPO_TRIG_CH1        2'h1
`define TPO_TRIG_CH2        2'h2

// ==========================================================================
// bus widths
// ==========================================================================
`define TPO_ADDR_W          22
`define TPO_DATA_W          32
`define TPO_IDX_W           20

`endif

// ---- design/tpo_group.v ----
// one 4-bit output group: trigger decode, staged data transfer and port data bits
`include "tpo_defs.vh"

module tpo_group
(
	input  wire       ref_clk,
	input  wire       rst_sync_b,
	input  wire       clr,
	input  wire [1:0] trig_sel,
	input  wire       nov,
	input  wire [2:0] cmp_a,
	input  wire [2:0] cmp_b,
	input  wire [3:0] enable,
	input  wire [3:0] staged,
	input  wire       wr_en,
	input  wire [3:0] wr_data,
	output reg  [3:0] data_r
);

	// ==========================================================================
	// trigger decode
	// ==========================================================================
	reg  [1:0] chan;     // selected timer channel
	wire       hit_a;    // compare match a of the selected channel
	wire       hit_b;    // compare match b of the selected channel
	wire [3:0] data_nxt; // next port data

	// 00 channel 0, 01 channel 1, 10 and 11 both channel 2
	always @*
	begin
		case (trig_sel)
			`TPO_TRIG_CH0: chan = 2'd0;
			`TPO_TRIG_CH1: chan = 2'd1;
			default:       chan = 2'd2;
		endcase
	end

	assign hit_a = cmp_a[chan];
	assign hit_b = cmp_b[chan];

	// ==========================================================================
	// per-bit next value
	// ==========================================================================
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1)
		begin : g_bit
			reg nb;
			// enabled bits take staged data only from the trigger, software writes are ignored
			always @*
			begin
				nb = data_r[i];
				if (enable[i])
				begin
					if (!nov)
					begin
						// normal mode: whole value copied at compare match a
						if (hit_a)
							nb = staged[i];
					end
					else
					begin
						// non-overlap: falling edges at b, rising edges after the margin at a
						if (hit_b && !staged[i])
							nb = 1'b0;
						if (hit_a && staged[i])
							nb = 1'b1;
					end
				end
				else if (wr_en)
				begin
					// disabled bits stay plain software data
					nb = wr_data[i];
				end
			end
			assign data_nxt[i] = nb;
		end
	endgenerate

	// ==========================================================================
	// port data bits
	// ==========================================================================
	// hardware standby clears like reset
	always @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
			data_r <= `TPO_RST_VAL;
		else if (clr)
			data_r <= `TPO_RST_VAL;
		else
			data_r <= data_nxt;
	end

endmodule

// ---- design/tpo_pattern_controller.v ----
// top of the timing pattern output block: apb registers, pin sync and four output groups
//
// Function
// - four independent 4-bit groups, numbered 3..0
// - per-group trigger from three timer channels
// - sixteen outputs, each bit enabled separately
// - non-overlap mode leaves margin between changes
// - direction registers write-only, reset to zero
// - enabled port data bits ignore software writes
// - trigger copies staged bits into port data
// - shared trigger: low stage whole byte, alt ones
// - split trigger: low nibbles split, rest ones
// - shared trigger: high stage whole byte, alt ones
// - split trigger: high nibbles split, rest ones
// - stage and enables cleared by reset, hardware standby
// - disabled bits keep value, enabled copy automatically
// - trigger field 00/01/1x channel, reset 11
// - non-overlap bit: normal at a, else a/b
// - enable without direction: input pin, still updated
`include "tpo_defs.vh"

module tpo_pattern_controller
(
	input  wire                      ref_clk,
	input  wire                      rst_b,
	input  wire                      hw_standby,
	input  wire                      sw_standby,
	input  wire [`TPO_ADDR_W-1:0]    paddr,
	input  wire                      psel,
	input  wire                      penable,
	input  wire                      pwrite,
	input  wire [`TPO_DATA_W-1:0]    pwdata,
	output reg  [`TPO_DATA_W-1:0]    prdata,
	output wire                      pready,
	output reg                       pslverr,
	input  wire [2:0]                cmp_a,
	input  wire [2:0]                cmp_b,
	input  wire [15:0]               pin_in,
	output wire [15:0]               pin_out,
	output wire [15:0]               pin_oe
);

	// ==========================================================================
	// reset release
	// ==========================================================================
	reg        rst_s1_r;   // first release stage
	reg        rst_sync_b; // released reset used by all logic

	// assert at once, release two edges later so no flop sees a ragged edge
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rst_s1_r   <= 1'b0;
			rst_sync_b <= 1'b0;
		end
		else
		begin
			rst_s1_r   <= 1'b1;
			rst_sync_b <= rst_s1_r;
		end
	end

	// ==========================================================================
	// pin and standby synchronisers
	// ==========================================================================
	reg [16:0] sy1_r;   // first stage, read only by the second
	reg [16:0] sy2_r;   // second stage
	reg [16:0] sy3_r;   // third stage
	reg [16:0] filt_r;  // accepted level once stages two and three agree
	wire [15:0] pin_val; // filtered pin levels
	wire        stby;    // filtered hardware standby

	// three flops, a change counts only when stages two and three match
	always @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			sy1_r  <= 17'h00000;
			sy2_r  <= 17'h00000;
			sy3_r  <= 17'h00000;
			filt_r <= 17'h00000;
		end
		else
		begin
			sy1_r  <= {hw_standby, pin_in};
			sy2_r  <= sy1_r;
			sy3_r  <= sy2_r;
			filt_r <= (~(sy2_r ^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & filt_r);
		end
	end

	assign pin_val = filt_r[15:0];
	assign stby    = filt_r[16];

	// ==========================================================================
	// apb decode
	// ==========================================================================
	wire [`TPO_IDX_W-1:0] idx;     // register index from the word address
	wire                  setup;   // setup phase of a transfer
	wire                  wr_acc;  // write takes effect this edge
	wire [7:0]            wd;      // write byte
	reg                   hit;     // index maps to a register
	wire                  lo_same; // groups 0 and 1 share a trigger
	wire                  hi_same; // groups 2 and 3 share a trigger
	wire [1:0]            ch0;     // decoded channel per group
	wire [1:0]            ch1;
	wire [1:0]            ch2;
	wire [1:0]            ch3;

	assign idx    = paddr[`TPO_ADDR_W-1:2];
	assign setup  = psel && !penable;
	assign pready = 1'b1; // zero wait states, every access completes in its first access cycle
	assign wr_acc = psel && penable && pwrite && hit;
	assign wd     = pwdata[7:0];

	// channel decode, 10 and 11 both meaning channel 2
	function [1:0] tpo_chan;
		input [1:0] f;
		begin
			tpo_chan = f[1] ? `TPO_TRIG_CH2 : f;
		end
	endfunction

	reg [7:0] trig_r; // group trigger fields, two bits per group

	assign ch0     = tpo_chan(trig_r[1:0]);
	assign ch1     = tpo_chan(trig_r[3:2]);
	assign ch2     = tpo_chan(trig_r[5:4]);
	assign ch3     = tpo_chan(trig_r[7:6]);
	assign lo_same = (ch0 == ch1);
	assign hi_same = (ch2 == ch3);

	// mapped indices; misaligned addresses are unmapped
	always @*
	begin
		hit = (paddr[1:0] == 2'b00);
		case (idx)
			`TPO_IDX_LO_DIR, `TPO_IDX_HI_DIR, `TPO_IDX_NOV_MODE, `TPO_IDX_TRIG_SEL,
			`TPO_IDX_HI_OE, `TPO_IDX_LO_OE, `TPO_IDX_HI_STG, `TPO_IDX_LO_STG,
			`TPO_IDX_HI_STG_ALT, `TPO_IDX_LO_STG_ALT, `TPO_IDX_LO_VAL, `TPO_IDX_HI_VAL:
				hit = hit;
			default:
				hit = 1'b0;
		endcase
	end

	// ==========================================================================
	// control registers
	// ==========================================================================
	reg [7:0] ddr_lo_r; // low port direction, write-only
	reg [7:0] ddr_hi_r; // high port direction, write-only
	reg [3:0] nov_r;    // per-group non-overlap bits
	reg [7:0] oe_lo_r;  // low per-bit output enables
	reg [7:0] oe_hi_r;  // high per-bit output enables
	reg [7:0] stg_lo_r; // low staged pattern
	reg [7:0] stg_hi_r; // high staged pattern

	// software standby leaves everything alone; reset and hardware standby clear
	always @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			ddr_lo_r <= `TPO_RST_DIR;
			ddr_hi_r <= `TPO_RST_DIR;
			nov_r    <= `TPO_RST_NOV;
			trig_r   <= `TPO_RST_TRIG;
			oe_lo_r  <= `TPO_RST_OE;
			oe_hi_r  <= `TPO_RST_OE;
			stg_lo_r <= `TPO_RST_STG;
			stg_hi_r <= `TPO_RST_STG;
		end
		else if (stby)
		begin
			ddr_lo_r <= `TPO_RST_DIR;
			ddr_hi_r <= `TPO_RST_DIR;
			nov_r    <= `TPO_RST_NOV;
			trig_r   <= `TPO_RST_TRIG;
			oe_lo_r  <= `TPO_RST_OE;
			oe_hi_r  <= `TPO_RST_OE;
			stg_lo_r <= `TPO_RST_STG;
			stg_hi_r <= `TPO_RST_STG;
		end
		else if (wr_acc)
		begin
			case (idx)
				`TPO_IDX_LO_DIR:   ddr_lo_r <= wd;
				`TPO_IDX_HI_DIR:   ddr_hi_r <= wd;
				`TPO_IDX_NOV_MODE: nov_r    <= wd[3:0];
				`TPO_IDX_TRIG_SEL: trig_r   <= wd;
				`TPO_IDX_LO_OE:    oe_lo_r  <= wd;
				`TPO_IDX_HI_OE:    oe_hi_r  <= wd;
				`TPO_IDX_LO_STG:
				begin
					// whole byte when shared, else only the group 1 nibble
					if (lo_same)
						stg_lo_r <= wd;
					else
						stg_lo_r[7:4] <= wd[7:4];
				end
				`TPO_IDX_LO_STG_ALT:
				begin
					// group 0 nibble only when triggers differ, otherwise ignored
					if (!lo_same)
						stg_lo_r[3:0] <= wd[3:0];
				end
				`TPO_IDX_HI_STG:
				begin
					if (hi_same)
						stg_hi_r <= wd;
					else
						stg_hi_r[7:4] <= wd[7:4];
				end
				`TPO_IDX_HI_STG_ALT:
				begin
					if (!hi_same)
						stg_hi_r[3:0] <= wd[3:0];
				end
				default:
				begin
					// port values are written inside the groups
				end
			endcase
		end
	end

	// ==========================================================================
	// output groups
	// ==========================================================================
	wire [15:0] en16;   // all per-bit enables
	wire [15:0] stg16;  // all staged bits
	wire [15:0] data16; // all port data bits
	wire        wr_lo;  // software write to low port value
	wire        wr_hi;  // software write to high port value

	assign en16  = {oe_hi_r, oe_lo_r};
	assign stg16 = {stg_hi_r, stg_lo_r};
	assign wr_lo = wr_acc && (idx == `TPO_IDX_LO_VAL);
	assign wr_hi = wr_acc && (idx == `TPO_IDX_HI_VAL);

	// each group runs off its own trigger field, untouched by the others
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_grp
			tpo_group u_grp
			(
				.ref_clk    (ref_clk),
				.rst_sync_b (rst_sync_b),
				.clr        (stby),
				.trig_sel   (trig_r[2*g+1:2*g]),
				.nov        (nov_r[g]),
				.cmp_a      (cmp_a),
				.cmp_b      (cmp_b),
				.enable     (en16[4*g+3:4*g]),
				.staged     (stg16[4*g+3:4*g]),
				.wr_en      ((g < 2) ? wr_lo : wr_hi),
				.wr_data    (wd[4*(g%2)+3:4*(g%2)]),
				.data_r     (data16[4*g+3:4*g])
			);
		end
	endgenerate

	// pins drive only where software set the direction; enabled inputs still update data
	assign pin_out = data16;
	assign pin_oe  = {ddr_hi_r, ddr_lo_r};

	// ==========================================================================
	// read path
	// ==========================================================================
	reg [7:0] rd; // read byte for the addressed register
	wire [15:0] port_rd; // port value as read: data where output, pin where input

	assign port_rd = (pin_oe & data16) | (~pin_oe & pin_val);

	always @*
	begin
		case (idx)
			`TPO_IDX_LO_DIR:     rd = `TPO_WO_READ;
			`TPO_IDX_HI_DIR:     rd = `TPO_WO_READ;
			`TPO_IDX_NOV_MODE:   rd = {`TPO_NOV_RSVD, nov_r};
			`TPO_IDX_TRIG_SEL:   rd = trig_r;
			`TPO_IDX_LO_OE:      rd = oe_lo_r;
			`TPO_IDX_HI_OE:      rd = oe_hi_r;
			`TPO_IDX_LO_STG:     rd = lo_same ? stg_lo_r : {stg_lo_r[7:4], `TPO_NIB_ONES};
			`TPO_IDX_LO_STG_ALT: rd = lo_same ? `TPO_BYTE_ONES : {`TPO_NIB_ONES, stg_lo_r[3:0]};
			`TPO_IDX_HI_STG:     rd = hi_same ? stg_hi_r : {stg_hi_r[7:4], `TPO_NIB_ONES};
			`TPO_IDX_HI_STG_ALT: rd = hi_same ? `TPO_BYTE_ONES : {`TPO_NIB_ONES, stg_hi_r[3:0]};
			`TPO_IDX_LO_VAL:     rd = port_rd[7:0];
			`TPO_IDX_HI_VAL:     rd = port_rd[15:8];
			default:             rd = 8'h00;
		endcase
	end

	// read data and error are captured in the setup cycle and stand through the access cycle
	always @(posedge ref_clk or negedge rst_sync_b)
	begin
		if (!rst_sync_b)
		begin
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else if (setup)
		begin
			prdata  <= (!pwrite && hit) ? {24'h000000, rd} : 32'h00000000;
			pslverr <= !hit;
		end
	end

endmodule

// ---- dv/tpo_timer_model.sv ----
// companion timer model: compare match strobes for three channels
module tpo_timer_model
(
	input  wire logic       ref_clk,
	input  wire logic       slow,
	input  wire logic [2:0] fire_a,
	input  wire logic [2:0] fire_b,
	output logic      [2:0] cmp_a,
	output logic      [2:0] cmp_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ======================================================================
	// strobe generation
	// ======================================================================
	// an extra stage lets a match come late as well as prompt
	logic [2:0] a_d = 3'h0;
	logic [2:0] b_d = 3'h0;
	// each request leaves as a strobe as long as the request, one edge later, or two when slow
	always @(posedge ref_clk)
	begin
		a_d <= fire_a;
		b_d <= fire_b;
		cmp_a <= slow ? a_d : fire_a;
		cmp_b <= slow ? b_d : fire_b;
	end
endmodule

// ---- dv/tpo_checker_asserts.sv ----
// concurrent checks on the pattern controller ports
`include "tpo_defs.vh"
module tpo_checker
(
	input wire        ref_clk,
	input wire        rst_b,
	input wire        hw_standby,
	input wire [21:0] paddr,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pslverr,
	input wire [2:0]  cmp_a,
	input wire [2:0]  cmp_b,
	input wire [15:0] pin_out,
	input wire [15:0] pin_oe
);
	// ======================================================================
	// helpers
	// ======================================================================
	localparam logic [21:0] A_LDIR = {`TPO_IDX_LO_DIR, 2'b00};
	localparam logic [21:0] A_HDIR = {`TPO_IDX_HI_DIR, 2'b00};
	localparam logic [21:0] A_NOV = {`TPO_IDX_NOV_MODE, 2'b00};
	localparam logic [21:0] A_LVAL = {`TPO_IDX_LO_VAL, 2'b00};
	localparam logic [21:0] A_HVAL = {`TPO_IDX_HI_VAL, 2'b00};
	localparam logic [21:0] A_BAD = 22'h000100;
	logic [2:0] quiet_r;
	wire setup = psel && !penable;
	wire wr = psel && penable && pwrite;
	wire quiet = quiet_r == 3'h7;
	// quiet only after reset and standby clears have fully landed
	always @(posedge ref_clk or negedge rst_b)
		if (!rst_b)
			quiet_r <= 3'h0;
		else if (hw_standby)
			quiet_r <= 3'h0;
		else if (!quiet)
			quiet_r <= quiet_r + 3'h1;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ======================================================================
	// assertions
	// ======================================================================
	property p_dir_wr;
		quiet && wr && paddr == A_LDIR |=> pin_oe[7:0] == $past(pwdata[7:0]);
	endproperty
	a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");
	property p_oe_hold;
		quiet && !(wr && (paddr == A_LDIR || paddr == A_HDIR)) |=> $stable(pin_oe);
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("direction moved");
	property p_dir_rd;
		setup && !pwrite && (paddr == A_LDIR || paddr == A_HDIR) |=> prdata == 32'h0;
	endproperty
	a_dir_rd: assert property (p_dir_rd) else $error("direction readable");
	property p_nov_rsvd;
		setup && !pwrite && paddr == A_NOV |=> prdata[7:4] == 4'hf;
	endproperty
	a_nov_rsvd: assert property (p_nov_rsvd) else $error("mode upper bits");
	property p_bad;
		setup && paddr == A_BAD |=> pslverr;
	endproperty
	a_bad: assert property (p_bad) else $error("no error on unmapped");
	property p_good;
		setup && paddr == A_NOV |=> !pslverr;
	endproperty
	a_good: assert property (p_good) else $error("error on mapped");
	property p_hold;
		quiet && cmp_a == 3'h0 && cmp_b == 3'h0 && !(wr && (paddr == A_LVAL || paddr == A_HVAL))
			|=> $stable(pin_out);
	endproperty
	a_hold: assert property (p_hold) else $error("port data moved");
	property p_standby;
		hw_standby [*6] |-> pin_out == 16'h0 && pin_oe == 16'h0;
	endproperty
	a_standby: assert property (p_standby) else $error("standby clear");
endmodule

bind tpo_pattern_controller tpo_checker u_chk
(
	.ref_clk, .rst_b, .hw_standby, .paddr, .psel, .penable, .pwrite, .pwdata,
	.prdata, .pslverr, .cmp_a, .cmp_b, .pin_out, .pin_oe
);

// ---- dv/tb_top.sv ----
// self-checking bench for the timing pattern output block
`include "tpo_defs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [19:0] LDIR = `TPO_IDX_LO_DIR, HDIR = `TPO_IDX_HI_DIR, NOV = `TPO_IDX_NOV_MODE,
		TRG = `TPO_IDX_TRIG_SEL, HOE = `TPO_IDX_HI_OE, LOE = `TPO_IDX_LO_OE, HST = `TPO_IDX_HI_STG,
		LST = `TPO_IDX_LO_STG, HSA = `TPO_IDX_HI_STG_ALT, LSA = `TPO_IDX_LO_STG_ALT, LVAL = `TPO_IDX_LO_VAL,
		HVAL = `TPO_IDX_HI_VAL;
	logic        ref_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        hw_standby = 1'b0;
	logic        sw_standby = 1'b0;
	logic [21:0] paddr = 22'h0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        slow = 1'b0;
	logic [2:0]  fire_a = 3'h0;
	logic [2:0]  fire_b = 3'h0;
	logic [2:0]  cmp_a;
	logic [2:0]  cmp_b;
	logic [15:0] pin_in = 16'h5a3c;
	logic [15:0] pin_out;
	logic [15:0] pin_oe;
	logic [15:0] po = 16'h0;
	logic [7:0]  rd;
	logic [7:0]  p;
	logic [1:0]  ch;
	logic        err;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles = 0;
	// reset values, with the low port reading back its pins
	logic [19:0] ri [9] = '{LDIR, HDIR, NOV, TRG, HOE, LOE, HST, LST, LVAL};
	logic [7:0]  rv [9] = '{8'h00, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h3c};

	tpo_pattern_controller uut
	(
		.ref_clk, .rst_b, .hw_standby, .sw_standby, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .cmp_a, .cmp_b, .pin_in, .pin_out, .pin_oe
	);
	tpo_timer_model u_tmr (.ref_clk, .slow, .fire_a, .fire_b, .cmp_a, .cmp_b);

	always #10 ref_clk = ~ref_clk;
	// ======================================================================
	// tasks
	// ======================================================================
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one transfer: setup, then access held until pready at an edge
	task automatic apb(input logic w, input logic [19:0] idx, input logic [7:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [19:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask
	task automatic rdchk(input logic [19:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk("read data", {8'h00, exp}, {8'h00, rd});
	endtask
	task automatic regs_reset();
		for (int i = 0; i < 9; i++)
			rdchk(ri[i], rv[i]);
	endtask
	// single-cycle match request, then room for a slow answer to land
	task automatic fire(input logic [2:0] a, input logic [2:0] b);
		@(posedge ref_clk);
		fire_a <= a;
		fire_b <= b;
		@(posedge ref_clk);
		fire_a <= 3'h0;
		fire_b <= 3'h0;
		repeat (4) @(posedge ref_clk);
	endtask
	// a hang is cut short well beyond the length of the whole sequence
	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 8000)
		begin
			fail_count++;
			end_of_test();
		end
	end
	// ======================================================================
	// sequence
	// ======================================================================
	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge ref_clk);
		regs_reset();
		apb(1'b0, 20'h00040, 8'h00);
		chk("unmapped error", 16'h1, {15'h0, err});
		$display("test reset values done");
		wr(LDIR, 8'hff);
		wr(HDIR, 8'hff);
		wr(LOE, 8'hff);
		wr(HOE, 8'hff);
		chk("pin_oe", 16'hffff, pin_oe);
		for (int c = 0; c < 4; c++)
		begin
			ch = (c > 1) ? 2'd2 : 2'(c);
			p = 8'h5a ^ 8'(c * 51);
			wr(TRG, {4{2'(c)}});
			wr(LST, p);
			wr(HST, ~p);
			fire(~(3'h1 << ch), 3'h1 << ch);
			chk("pin_out other channel", po, pin_out);
			fire(3'h1 << ch, 3'h0);
			po = {~p, p};
			chk("pin_out selected", po, pin_out);
		end
		$display("test trigger select done");
		wr(TRG, 8'ha4);
		wr(LST, 8'hc3);
		rdchk(LST, 8'hcf);
		wr(LSA, 8'h96);
		rdchk(LSA, 8'hf6);
		rdchk(HSA, 8'hff);
		fire(3'h1, 3'h0);
		po[3:0] = 4'h6;
		chk("pin_out group 0", po, pin_out);
		fire(3'h2, 3'h0);
		po[7:4] = 4'hc;
		chk("pin_out group 1", po, pin_out);
		// high pair split as well: group 3 on channel 1, group 2 on channel 2
		wr(TRG, 8'h64);
		wr(HST, 8'h5a);
		rdchk(HST, 8'h5f);
		wr(HSA, 8'h81);
		rdchk(HSA, 8'hf1);
		fire(3'h4, 3'h0);
		po[11:8] = 4'h1;
		chk("pin_out group 2", po, pin_out);
		fire(3'h2, 3'h0);
		po[15:12] = 4'h5;
		chk("pin_out group 3", po, pin_out);
		// enabled high port bits read back data and ignore software writes
		wr(HVAL, 8'h00);
		rdchk(HVAL, 8'h51);
		$display("test split trigger done");
		wr(LOE, 8'h0f);
		wr(LDIR, 8'hf0);
		wr(LVAL, 8'h00);
		@(posedge ref_clk);
		po[7:4] = 4'h0;
		chk("pin_out write", po, pin_out);
		chk("pin_oe", 16'hfff0, pin_oe);
		wr(TRG, 8'h00);
		wr(LST, 8'hff);
		fire(3'h1, 3'h0);
		po[3:0] = 4'hf;
		chk("pin_out enables", po, pin_out);
		rdchk(LVAL, 8'h0c);
		$display("test enables done");
		slow <= 1'b1;
		wr(NOV, 8'h01);
		wr(LST, 8'h05);
		fire(3'h1, 3'h0);
		fire(3'h0, 3'h1);
		po[3:0] = 4'h5;
		chk("pin_out margin fall", po, pin_out);
		wr(LST, 8'h0a);
		fire(3'h1, 3'h0);
		po[3:0] = 4'hf;
		chk("pin_out margin rise", po, pin_out);
		$display("test non-overlap done");
		sw_standby <= 1'b1;
		rdchk(LOE, 8'h0f);
		sw_standby <= 1'b0;
		hw_standby <= 1'b1;
		repeat (8) @(posedge ref_clk);
		hw_standby <= 1'b0;
		repeat (6) @(posedge ref_clk);
		chk("pin_out standby", 16'h0, pin_out);
		regs_reset();
		$display("test standby done");
		end_of_test();
	end
endmodule
